// ---- hak_cfg.svh ----
`ifndef HAK_CFG_SVH
`define HAK_CFG_SVH

`define HAK_KEY_ADDR    16'hE7FE
`define HAK_WPCTL_ADDR  16'hE7E3
`define HAK_TUNE_ADDR   16'hE90C
`define HAK_WAVE_LO     16'hE880
`define HAK_WAVE_HI     16'hE89F
`define HAK_ADDR_STEP   16'h0001
`define HAK_KEY_VAL     8'hAD
`define HAK_RELOCK_VAL  8'h00
`define HAK_WP_ON_VAL   8'h80
`define HAK_WP_OFF_VAL  8'h00
`define HAK_TUNE_RST    16'h0000
`define HAK_WPCTL_RST   8'h00
`define HAK_ADDR_RST    16'h0000
`define HAK_DATA_RST    32'h0000_0000

`endif

// ---- hak_pkg.sv ----
package hak_pkg;

   typedef enum logic [1:0] {
      HAK_SZ8,
      HAK_SZ16,
      HAK_SZ32
   } hak_size_type;

   typedef struct packed {
      logic         wr;
      logic         via_i2c;
      logic         burst;
      hak_size_type size;
      logic [15:0]  addr;
      logic [31:0]  wdata;
   } hak_access_type;

endpackage : hak_pkg

// ---- hak_capture.sv ----
`timescale 1ns/1ps
`include "hak_cfg.svh"

module hak_capture (
   input  wire logic                    clk_i,
   input  wire logic                    nrst_i,
   input  wire logic                    req_valid_i,
   input  wire hak_pkg::hak_access_type req_i,
   input  wire logic [31:0]             rdata_i,
   input  wire logic [31:0]             rdata_alt_i,
   output logic [15:0]                  last_addr_o,
   output logic [31:0]                  last_data_o
);
   import hak_pkg::*;

   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic [31:0] data_reg;
   logic [31:0] data_next;
   logic        fault;

   always_comb begin
      fault = req_i.burst && !req_i.via_i2c && !req_i.wr &&
              req_i.addr >= `HAK_WAVE_LO && req_i.addr <= `HAK_WAVE_HI; // R2 R3
      addr_next = addr_reg;
      data_next = data_reg;
      if (req_valid_i) begin
         if (fault) begin
            // silicon quirk kept on purpose: software works around it
            addr_next = req_i.addr + `HAK_ADDR_STEP; // R2
            data_next = rdata_alt_i; // R2
         end else begin
            addr_next = req_i.addr; // R1 R3
            data_next = req_i.wr ? req_i.wdata : rdata_i; // R1
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr_reg <= `HAK_ADDR_RST;
         data_reg <= `HAK_DATA_RST;
      end else begin
         addr_reg <= addr_next;
         data_reg <= data_next;
      end
   end

   assign last_addr_o = addr_reg;
   assign last_data_o = data_reg;

endmodule : hak_capture

// ---- hak_access_check.sv ----
`timescale 1ns/1ps
`include "hak_cfg.svh"

// Notes on behaviour
// R1 - every access records address and value
// R2 - burst spi waveform reads record address plus one
// R3 - i2c accesses record the true address
// R4 - host does another access before trusting record
// R5 - key 0xAD write unlocks protected setting
// R6 - then 16-bit write stages new setting
// R7 - key 0x00 write relocks and commits
// R8 - sequence honoured only when uninterrupted
// R9 - 16-bit read returns stored setting
// R10 - key then 0x80 enables memory protection
// R11 - key then 0x00 disables memory protection
// R12 - unkeyed protected write is ignored
module hak_access_check (
   input  wire logic                    clk_i,
   input  wire logic                    nrst_i,
   input  wire logic                    req_valid_i,
   input  wire hak_pkg::hak_access_type req_i,
   input  wire logic [31:0]             ext_rdata_i,
   input  wire logic [31:0]             ext_rdata_alt_i,
   output logic                         rsp_valid_o,
   output logic [31:0]                  rsp_rdata_o,
   output logic [15:0]                  last_addr_o,
   output logic [31:0]                  last_access_value_o,
   output logic [15:0]                  tuning_o,
   output logic                         wp_enable_o,
   output logic                         unlocked_o
);
   import hak_pkg::*;

   typedef enum logic [1:0] {
      ST_LOCKED,
      ST_KEYED,
      ST_STAGED
   } hak_state_type;

   hak_state_type state_reg;
   hak_state_type state_next;
   logic [15:0]   tune_reg;
   logic [15:0]   tune_next;
   logic [15:0]   pend_reg;
   logic [15:0]   pend_next;
   logic [7:0]    wpctl_reg;
   logic [7:0]    wpctl_next;
   logic          rsp_valid_reg;
   logic          rsp_valid_next;
   logic [31:0]   rsp_rdata_reg;
   logic [31:0]   rsp_rdata_next;
   logic          wp_en_reg;
   logic          wp_en_next;
   logic          unlocked_reg;
   logic          unlocked_next;
   logic [31:0]   rdata;
   logic          is_wr;
   logic          wr_key;
   logic          wr_tune;
   logic          wr_wpctl;

   always_comb begin
      is_wr    = req_valid_i && req_i.wr;
      wr_key   = is_wr && req_i.size == HAK_SZ8 &&
                 req_i.addr == `HAK_KEY_ADDR;
      wr_tune  = is_wr && req_i.size == HAK_SZ16 &&
                 req_i.addr == `HAK_TUNE_ADDR;
      wr_wpctl = is_wr && req_i.size == HAK_SZ8 &&
                 req_i.addr == `HAK_WPCTL_ADDR;
      // key register is write-only and reads as zero
      unique case (req_i.addr)
         `HAK_TUNE_ADDR:  rdata = {16'h0000, tune_reg}; // R9
         `HAK_WPCTL_ADDR: rdata = {24'h00_0000, wpctl_reg};
         `HAK_KEY_ADDR:   rdata = 32'h0000_0000;
         default:         rdata = ext_rdata_i;
      endcase
   end

   // key sequencer: any access out of place drops back to locked
   always_comb begin
      state_next = state_reg;
      tune_next  = tune_reg;
      pend_next  = pend_reg;
      wpctl_next = wpctl_reg;
      if (req_valid_i) begin
         state_next = ST_LOCKED; // R8 R12
         unique case (state_reg)
            ST_LOCKED: begin
               if (wr_key && req_i.wdata[7:0] == `HAK_KEY_VAL) begin
                  state_next = ST_KEYED; // R5
               end
            end
            ST_KEYED: begin
               if (wr_tune) begin
                  pend_next  = req_i.wdata[15:0]; // R6
                  state_next = ST_STAGED; // R6
               end else if (wr_wpctl) begin
                  wpctl_next = req_i.wdata[7:0]; // R10 R11
               end else if (wr_key &&
                            req_i.wdata[7:0] == `HAK_KEY_VAL) begin
                  state_next = ST_KEYED; // R5
               end
            end
            ST_STAGED: begin
               // commit only here so an interrupted sequence has no effect
               if (wr_key && req_i.wdata[7:0] == `HAK_RELOCK_VAL) begin
                  tune_next = pend_reg; // R7 R8
               end
            end
            default: state_next = ST_LOCKED;
         endcase
      end
   end

   always_comb begin
      rsp_valid_next = req_valid_i;
      rsp_rdata_next = (req_valid_i && !req_i.wr) ? rdata : rsp_rdata_reg;
      // decoded ahead so both flags leave straight from a flop
      wp_en_next     = wpctl_next == `HAK_WP_ON_VAL; // R10 R11
      unlocked_next  = state_next != ST_LOCKED; // R5 R7
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg     <= ST_LOCKED;
         tune_reg      <= `HAK_TUNE_RST;
         pend_reg      <= `HAK_TUNE_RST;
         wpctl_reg     <= `HAK_WPCTL_RST;
         rsp_valid_reg <= 1'b0;
         rsp_rdata_reg <= `HAK_DATA_RST;
         wp_en_reg     <= 1'b0;
         unlocked_reg  <= 1'b0;
      end else begin
         state_reg     <= state_next;
         tune_reg      <= tune_next;
         pend_reg      <= pend_next;
         wpctl_reg     <= wpctl_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_rdata_reg <= rsp_rdata_next;
         wp_en_reg     <= wp_en_next;
         unlocked_reg  <= unlocked_next;
      end
   end

   hak_capture u_capture (
      .clk_i       (clk_i),
      .nrst_i      (nrst_i),
      .req_valid_i (req_valid_i),
      .req_i       (req_i),
      .rdata_i     (rdata),
      .rdata_alt_i (ext_rdata_alt_i),
      .last_addr_o (last_addr_o),
      .last_data_o (last_access_value_o)
   );

   assign rsp_valid_o = rsp_valid_reg;
   assign rsp_rdata_o = rsp_rdata_reg;
   assign tuning_o    = tune_reg;
   assign wp_enable_o = wp_en_reg;
   assign unlocked_o  = unlocked_reg;

   logic wave_burst;
   assign wave_burst = req_valid_i && req_i.burst && !req_i.via_i2c &&
                       !req_i.wr && req_i.addr >= `HAK_WAVE_LO &&
                       req_i.addr <= `HAK_WAVE_HI;

   property p_cap_plain;
      @(posedge clk_i) disable iff (!nrst_i)
      (req_valid_i && !wave_burst) |=>
         last_addr_o == $past(req_i.addr) &&
         last_access_value_o == ($past(req_i.wr) ? $past(req_i.wdata)
                                                 : $past(rdata));
   endproperty
   a_cap_plain: assert property (p_cap_plain) // R1
      else $error("last access record wrong");

   property p_cap_fault;
      @(posedge clk_i) disable iff (!nrst_i)
      wave_burst |=>
         last_addr_o == 16'($past(req_i.addr) + `HAK_ADDR_STEP) &&
         last_access_value_o == $past(ext_rdata_alt_i);
   endproperty
   a_cap_fault: assert property (p_cap_fault) // R2
      else $error("burst waveform record not offset");

   property p_cap_i2c;
      @(posedge clk_i) disable iff (!nrst_i)
      (req_valid_i && req_i.via_i2c) |=> last_addr_o == $past(req_i.addr);
   endproperty
   a_cap_i2c: assert property (p_cap_i2c) // R3
      else $error("i2c record address wrong");

   property p_unlock;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_LOCKED && wr_key &&
       req_i.wdata[7:0] == `HAK_KEY_VAL) |=> unlocked_o;
   endproperty
   a_unlock: assert property (p_unlock) // R5
      else $error("key did not unlock");

   property p_stage;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_KEYED && wr_tune) |=>
         state_reg == ST_STAGED && $stable(tune_reg);
   endproperty
   a_stage: assert property (p_stage) // R6
      else $error("protected write not staged");

   property p_commit;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_STAGED && wr_key &&
       req_i.wdata[7:0] == `HAK_RELOCK_VAL) |=>
         !unlocked_o && tuning_o == $past(pend_reg);
   endproperty
   a_commit: assert property (p_commit) // R7
      else $error("relock did not commit");

   property p_broken;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_STAGED && req_valid_i &&
       !(wr_key && req_i.wdata[7:0] == `HAK_RELOCK_VAL)) |=>
         !unlocked_o && $stable(tuning_o);
   endproperty
   a_broken: assert property (p_broken) // R8
      else $error("interrupted sequence took effect");

   property p_readback;
      @(posedge clk_i) disable iff (!nrst_i)
      (req_valid_i && !req_i.wr && req_i.addr == `HAK_TUNE_ADDR) |=>
         rsp_valid_o && rsp_rdata_o[15:0] == $past(tune_reg);
   endproperty
   a_readback: assert property (p_readback) // R9
      else $error("setting read back wrong");

   property p_wp_on;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_KEYED && wr_wpctl &&
       req_i.wdata[7:0] == `HAK_WP_ON_VAL) |=> wp_enable_o && !unlocked_o;
   endproperty
   a_wp_on: assert property (p_wp_on) // R10
      else $error("protection not enabled");

   property p_wp_off;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_KEYED && wr_wpctl &&
       req_i.wdata[7:0] == `HAK_WP_OFF_VAL) |=> !wp_enable_o;
   endproperty
   a_wp_off: assert property (p_wp_off) // R11
      else $error("protection not disabled");

   property p_ignore;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == ST_LOCKED && wr_tune) |=> $stable(tuning_o);
   endproperty
   a_ignore: assert property (p_ignore) // R12
      else $error("unkeyed write changed setting");

endmodule : hak_access_check

// ---- hak_regfile_model.sv ----
`timescale 1ns/1ps

module hak_regfile_model (
   input  wire logic [15:0] addr_i,
   output logic [31:0]      rdata_o,
   output logic [31:0]      rdata_alt_o
);
   // every address reads differently, so a wrong pick shows
   assign rdata_o     = {~addr_i, addr_i};
   assign rdata_alt_o = {~(addr_i + 16'h0001), addr_i + 16'h0001};
endmodule : hak_regfile_model

// ---- hak_access_check_tb.sv ----
`timescale 1ns/1ps
`include "hak_cfg.svh"

module hak_access_check_tb;
   import hak_pkg::*;
   logic           clk_i, nrst_i, req_valid_i, rsp_valid_o;
   logic           wp_enable_o, unlocked_o;
   hak_access_type req_i;
   logic [31:0]    ext_rdata_i, ext_rdata_alt_i, rsp_rdata_o;
   logic [31:0]    last_access_value_o, rd;
   logic [15:0]    last_addr_o, tuning_o, tune, staged;
   logic [7:0]     ctl;
   logic [97:0]    notes[$];
   logic [15:0]    wa[5] = '{16'hE87F, 16'hE880, 16'hE890, 16'hE89F, 16'hE8A0};
   logic [7:0]     pv[4] = '{8'h80, 8'h00, 8'h81, 8'h80};
   int             errors = 0, comparisons = 0, cycles = 0, st;

   hak_access_check dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
      .req_valid_i(req_valid_i), .req_i(req_i),
      .ext_rdata_i(ext_rdata_i), .ext_rdata_alt_i(ext_rdata_alt_i),
      .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
      .last_addr_o(last_addr_o), .last_access_value_o(last_access_value_o),
      .tuning_o(tuning_o), .wp_enable_o(wp_enable_o),
      .unlocked_o(unlocked_o));
   hak_regfile_model regs_u (.addr_i(req_i.addr), .rdata_o(ext_rdata_i),
      .rdata_alt_o(ext_rdata_alt_i));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic summarize;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic cmp(input logic [97:0] exp, input logic [97:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t exp %h got %h", $time, exp, got);
      end
   endtask : cmp

   always @(negedge clk_i) begin
      if (rsp_valid_o === 1'b1) begin
         if (notes.size() > 0)
            cmp(notes.pop_front(), {rsp_rdata_o, last_addr_o,
               last_access_value_o, tuning_o, wp_enable_o, unlocked_o});
         else
            cmp('1, '0);
      end
   end

   // hang guard, far above the roughly 106 cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         summarize();
      end
   end

   task automatic acc(input logic w, input logic i2c, input logic b,
         input hak_size_type sz, input logic [15:0] a, input logic [31:0] d);
      logic [15:0] la;
      logic [31:0] lv, rv;
      logic        key;
      req_valid_i = 1'b1;
      req_i = '{w, i2c, b, sz, a, d};
      key = w && sz == HAK_SZ8 && a == `HAK_KEY_ADDR;
      rv = (a == `HAK_TUNE_ADDR) ? {16'h0, tune} : (a == `HAK_KEY_ADDR) ?
         32'h0 : (a == `HAK_WPCTL_ADDR) ? {24'h0, ctl} : {~a, a};
      la = a;
      lv = w ? d : rv;
      if (!w && !i2c && b && a >= `HAK_WAVE_LO && a <= `HAK_WAVE_HI) begin
         la = a + `HAK_ADDR_STEP;
         lv = {~la, la};
      end
      if (!w)
         rd = rv;
      // a staged sequence broken by a fresh key drops back to locked
      if (key && d[7:0] == `HAK_KEY_VAL && st != 2)
         st = 1;
      else if (st == 1 && w && sz == HAK_SZ16 && a == `HAK_TUNE_ADDR) begin
         staged = d[15:0];
         st = 2;
      end else if (st == 2 && key && d[7:0] == `HAK_RELOCK_VAL) begin
         tune = staged;
         st = 0;
      end else if (st == 1 && w && sz == HAK_SZ8 && a == `HAK_WPCTL_ADDR) begin
         ctl = d[7:0];
         st = 0;
      end else
         st = 0;
      notes.push_back({rd, la, lv, tune, ctl == `HAK_WP_ON_VAL, st != 0});
      @(posedge clk_i);
      #1;
   endtask : acc

   task automatic idle(input string msg);
      req_valid_i = 1'b0;
      @(posedge clk_i);
      #1;
      $display("%s done", msg);
   endtask : idle

   // brk 1/2 wedge another access in, 3 uses the wrong size
   task automatic upd(input logic [15:0] v, input int brk);
      acc(1, 0, 0, HAK_SZ8, `HAK_KEY_ADDR, 32'hAD);
      if (brk == 1) acc(0, 1, 0, HAK_SZ32, 16'h0200, 0);
      acc(1, 0, 0, (brk == 3) ? HAK_SZ32 : HAK_SZ16, `HAK_TUNE_ADDR,
         {16'h0, v});
      if (brk == 2) acc(1, 0, 0, HAK_SZ8, 16'h0201, 0);
      acc(1, 0, 0, HAK_SZ8, `HAK_KEY_ADDR, 32'h00);
      acc(0, 0, 0, HAK_SZ16, `HAK_TUNE_ADDR, 0);
   endtask : upd

   initial begin
      nrst_i = 1'b0;
      req_valid_i = 1'b0;
      req_i = '0;
      {tune, staged, ctl, rd, st} = '0;
      void'($urandom(84993));
      repeat (20) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      acc(0, 0, 0, HAK_SZ16, `HAK_TUNE_ADDR, 0);
      for (int i = 0; i < 24; i++)
         acc($urandom % 2, $urandom % 2, $urandom % 2, HAK_SZ32,
            16'($urandom % 16'hE700), $urandom);
      idle("random traffic");
      foreach (wa[k])
         for (int v = 0; v < 4; v++)
            acc(0, v[1], v[0], HAK_SZ32, wa[k], 0);
      acc(1, 0, 0, HAK_SZ32, 16'h0100, $urandom);
      idle("waveform record");
      upd(16'h03BD, 0);
      for (int b = 1; b < 4; b++)
         upd(16'($urandom), b);
      acc(1, 0, 0, HAK_SZ16, `HAK_TUNE_ADDR, $urandom % 16'hFFFF);
      upd(16'($urandom), 0);
      idle("setting update");
      foreach (pv[k]) begin
         acc(1, 0, 0, HAK_SZ8, `HAK_KEY_ADDR, 32'hAD);
         acc(1, 0, 0, HAK_SZ8, `HAK_WPCTL_ADDR, {24'h0, pv[k]});
         acc(0, 1, 0, HAK_SZ8, `HAK_WPCTL_ADDR, 0);
      end
      idle("protection");
      idle("drain");
      cmp(98'(notes.size()), 98'd0);
      summarize();
   end
endmodule : hak_access_check_tb
